// File: core/quad_dac_regs.svh
`ifndef QUAD_DAC_REGS_SVH
`define QUAD_DAC_REGS_SVH

// frame layout: command byte then 16 data bits, msb first
`define FRAME_BITS     24
`define CNT_W          5
`define CODE_W         16
`define ADDR_LSB       0
`define ADDR_MSB       3

// write targets (low nibble of command byte)
`define ADDR_GPIO      4'h0
`define ADDR_GAIN      4'h1
`define ADDR_ZERO      4'h2
`define ADDR_CH0       4'h4
`define ADDR_CH3       4'h7

// reset values and the bipolar sign-flip mask
`define GAIN_RESET     16'h8000
`define ZERO_RESET     16'h0000
`define CODE_ZERO_UNI  16'h0000
`define CODE_ZERO_BIP  16'h0000
`define BIP_FLIP       16'h8000

`endif

// File: core/quad_dac_pkg.sv
package quad_dac_pkg;

  typedef logic [15:0] code_t;

  typedef struct packed {
    logic [7:0] cmd;
    code_t      data;
  } frame_s;

  typedef struct packed {
    logic       load_n;
    logic       reset_n;
    logic [1:0] bipolar;
    logic [1:0] gpio;
  } pins_s;

endpackage : quad_dac_pkg

// File: core/serial_link.sv
`timescale 1ns/1ps
`include "quad_dac_regs.svh"

module serial_link
  import quad_dac_pkg::*;
(
  input  wire logic   sclk,
  input  wire logic   rst,
  input  wire logic   cs_n,
  input  wire logic   sdi,
  output frame_s      frame,
  output logic        frame_toggle,
  output logic        sdo
);

  logic [`FRAME_BITS-1:0] shift;
  logic [`FRAME_BITS-1:0] next_shift;
  logic [`CNT_W-1:0]      cnt;
  logic [`CNT_W-1:0]      next_cnt;
  frame_s                 next_frame;
  logic                   next_toggle;
  logic                   done;

  always_comb begin
    done        = (cnt == 5'(`FRAME_BITS - 1));
    next_shift  = {shift[`FRAME_BITS-2:0], sdi};  // R1
    next_cnt    = done ? '0 : cnt + 5'd1;
    next_frame  = done ? frame_s'(next_shift) : frame;
    next_toggle = done ? ~frame_toggle : frame_toggle;
  end

  // bit counter restarts whenever the host raises select, so a torn
  // frame never lands; shifting itself needs select low
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt <= '0;  // R1
    end else begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      shift        <= next_shift;  // R1
      frame        <= next_frame;
    end
  end

  // toggle must start known or no frame is ever seen; the link clock
  // is parked while rst is up, so the clear cannot race an edge
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      frame_toggle <= 1'b0;
    end else if (!cs_n) begin
      frame_toggle <= next_toggle;
    end
  end

  // echo out on the falling edge so the host samples on the rising one
  always_ff @(negedge sclk) begin
    sdo <= shift[`FRAME_BITS-1];
  end

endmodule : serial_link

// File: core/quad_dac_pin_control.sv
`timescale 1ns/1ps
`include "quad_dac_regs.svh"

// Overview of operation
// (R1) shift data only while select held low
// (R2) serial output released while select high
// (R3) load low makes latches follow input registers
// (R4) outputs change together with latch update
// (R5) reset pin restores registers per polarity
// (R6) reset pin restores gain and zero calibration
// (R7) general pins only pull low or release
// (R8) group a polarity pin high means unipolar
// (R9) unipolar straight binary, bipolar twos complement
// (R10) channels 0-1 group a, 2-3 group b
// (R11) 16-bit input register and latch per channel
module quad_dac_pin_control
  import quad_dac_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         sclk,
  input  wire logic         cs_n,
  input  wire logic         sdi,
  output logic              sdo,
  output logic              sdo_oe,
  input  wire logic         latch_load_n,
  input  wire logic         reset_pin_n,
  input  wire logic         group_a_polarity_sel,
  input  wire logic         group_b_polarity_sel,
  input  wire logic [1:0]   gpio_i,
  output logic      [1:0]   gpio_o,
  output logic      [1:0]   gpio_oe,
  output logic      [1:0]   gpio_state,
  output code_t             dac_level [4],
  output logic      [1:0]   group_bipolar,
  output code_t             gain_cal,
  output code_t             zero_cal
);

  // reset value of a channel follows its group coding
  function automatic code_t reset_code(input logic bip);
    return bip ? `CODE_ZERO_BIP : `CODE_ZERO_UNI;  // R5
  endfunction : reset_code

  // analog level as an unsigned code; bipolar flips the sign bit
  function automatic code_t to_level(input code_t c, input logic bip);
    return bip ? (c ^ `BIP_FLIP) : c;  // R9
  endfunction : to_level

  // channel index to group: 0,1 -> a, 2,3 -> b
  function automatic logic grp(input int ch);
    return (ch >= 2);  // R10
  endfunction : grp

  // ---------------- link domain ----------------
  frame_s link_frame;
  logic   link_toggle;
  logic   link_sdo;

  serial_link u_link (
    .sclk         (sclk),
    .rst          (rst),
    .cs_n         (cs_n),
    .sdi          (sdi),
    .frame        (link_frame),
    .frame_toggle (link_toggle),
    .sdo          (link_sdo)
  );

  assign sdo = link_sdo;

  // ---------------- synchronisers ----------------
  pins_s      pin_raw;
  pins_s      pin_s1;
  pins_s      pin_s2;
  logic [2:0] tog_sync;
  logic [2:0] next_tog_sync;
  logic [1:0] cs_sync;
  logic [1:0] next_cs_sync;
  pins_s      next_pin_s1;
  pins_s      next_pin_s2;

  always_comb begin
    pin_raw.load_n  = latch_load_n;
    pin_raw.reset_n = reset_pin_n;
    // pin high selects unipolar, so bipolar is its inverse
    pin_raw.bipolar = {~group_b_polarity_sel, ~group_a_polarity_sel};  // R8
    pin_raw.gpio    = gpio_i;
    next_pin_s1     = pin_raw;
    next_pin_s2     = pin_s1;
    next_tog_sync   = {tog_sync[1:0], link_toggle};
    next_cs_sync    = {cs_sync[0], cs_n};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1   <= '{load_n: 1'b1, reset_n: 1'b1, bipolar: 2'h0, gpio: 2'h3};
      pin_s2   <= '{load_n: 1'b1, reset_n: 1'b1, bipolar: 2'h0, gpio: 2'h3};
      tog_sync <= 3'h0;
      cs_sync  <= 2'h3;
    end else if (ce) begin
      pin_s1   <= next_pin_s1;
      pin_s2   <= next_pin_s2;
      tog_sync <= next_tog_sync;
      cs_sync  <= next_cs_sync;
    end
  end

  // ---------------- serial output enable ----------------
  // follows select through the synchroniser: a few clocks late, the
  // price of keeping every output but sdo on a flip-flop of this domain
  logic next_sdo_oe;

  always_comb begin
    next_sdo_oe = ~cs_sync[1];  // R2
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sdo_oe <= 1'b0;
    end else if (ce) begin
      sdo_oe <= next_sdo_oe;
    end
  end

  // ---------------- register file ----------------
  code_t      in_reg [4];
  code_t      latch [4];
  code_t      next_in_reg [4];
  code_t      next_latch [4];
  code_t      next_level [4];
  code_t      next_gain;
  code_t      next_zero;
  logic [1:0] drive_low;
  logic [1:0] next_drive_low;
  logic       frame_new;
  logic       dev_reset;
  logic [3:0] waddr;

  always_comb begin
    // frame word is stable for many clocks after the toggle moves
    frame_new      = tog_sync[2] ^ tog_sync[1];
    dev_reset      = ~pin_s2.reset_n;
    waddr          = link_frame.cmd[`ADDR_MSB:`ADDR_LSB];
    next_gain      = gain_cal;
    next_zero      = zero_cal;
    next_drive_low = drive_low;
    for (int ch = 0; ch < 4; ch++) begin
      next_in_reg[ch] = in_reg[ch];
    end
    if (frame_new) begin
      unique case (waddr) inside
        `ADDR_GPIO:            next_drive_low = link_frame.data[1:0];
        `ADDR_GAIN:            next_gain      = link_frame.data;
        `ADDR_ZERO:            next_zero      = link_frame.data;
        [`ADDR_CH0:`ADDR_CH3]: next_in_reg[waddr[1:0]] = link_frame.data;
        default:               next_gain      = gain_cal;
      endcase
    end
    for (int ch = 0; ch < 4; ch++) begin
      // transparent while load is low, holds otherwise
      next_latch[ch] = pin_s2.load_n ? latch[ch] : next_in_reg[ch];  // R3 R11
    end
    if (dev_reset) begin
      next_gain      = `GAIN_RESET;  // R6
      next_zero      = `ZERO_RESET;  // R6
      next_drive_low = 2'h0;
      for (int ch = 0; ch < 4; ch++) begin
        next_in_reg[ch] = reset_code(pin_s2.bipolar[grp(ch)]);  // R5
        next_latch[ch]  = reset_code(pin_s2.bipolar[grp(ch)]);  // R5
      end
    end
    for (int ch = 0; ch < 4; ch++) begin
      // level taken from the new latch value so it moves on the same edge
      next_level[ch] = to_level(next_latch[ch], pin_s2.bipolar[grp(ch)]);  // R4 R9
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gain_cal  <= `GAIN_RESET;
      zero_cal  <= `ZERO_RESET;
      drive_low <= 2'h0;
      for (int ch = 0; ch < 4; ch++) begin
        in_reg[ch]    <= 16'h0000;
        latch[ch]     <= 16'h0000;
        dac_level[ch] <= 16'h0000;
      end
    end else if (ce) begin
      gain_cal  <= next_gain;
      zero_cal  <= next_zero;
      drive_low <= next_drive_low;
      for (int ch = 0; ch < 4; ch++) begin
        in_reg[ch]    <= next_in_reg[ch];
        latch[ch]     <= next_latch[ch];
        dac_level[ch] <= next_level[ch];
      end
    end
  end

  // ---------------- general pins and status ----------------
  logic [1:0] next_gpio_oe;
  logic [1:0] next_state;
  logic [1:0] next_bip;

  always_comb begin
    next_gpio_oe = next_drive_low;  // R7
    next_state   = pin_s2.gpio;
    next_bip     = pin_s2.bipolar;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_o        <= 2'h0;
      gpio_oe       <= 2'h0;
      gpio_state    <= 2'h3;
      group_bipolar <= 2'h0;
    end else if (ce) begin
      gpio_o        <= 2'h0;  // R7
      gpio_oe       <= next_gpio_oe;
      gpio_state    <= next_state;
      group_bipolar <= next_bip;
    end
  end

endmodule : quad_dac_pin_control

// File: sim/spi_host.sv
`timescale 1ns/1ps
module spi_host (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input  logic sdo
);
  // bits seen on sdo at each rising edge, msb first
  logic [23:0] rx;
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    sdi  = 1'h0;
  end
  // clock parked low between frames; released data line flips so stale bits are not trusted
  task automatic xfer(input logic [23:0] w, input int n);
    #9 cs_n = 1'h0;
    for (int i = 23; i > 23 - n; i--) begin
      sdi = w[i];
      #16 rx = {rx[22:0], sdo};
      sclk = 1'h1;
      #16 sclk = 1'h0;
    end
    #16 cs_n = 1'h1;
    sdi = ~sdi;
  endtask : xfer
endmodule : spi_host

// File: sim/quad_dac_pin_control_sva.sv
`timescale 1ns/1ps
module quad_dac_pin_control_sva
  import quad_dac_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       cs_n,
  input wire logic       sdo_oe,
  input wire logic       latch_load_n,
  input wire logic       reset_pin_n,
  input wire logic       group_a_polarity_sel,
  input wire logic       group_b_polarity_sel,
  input wire logic [1:0] gpio_o,
  input wire logic [1:0] group_bipolar,
  input wire code_t      gain_cal,
  input wire code_t      zero_cal,
  input wire code_t      dac_level [4]
);
  default clocking @(posedge clk); endclocking
  // a low enable freezes the synchronisers, so no timing below holds then
  default disable iff (rst || !ce);
  sequence s_rp; !reset_pin_n[*4]; endsequence
  // polarity held long enough that the bipolar flip cannot move the levels
  sequence s_hold;
    (latch_load_n && reset_pin_n)[*4] and
      $stable({group_a_polarity_sel, group_b_polarity_sel})[*4];
  endsequence
  property p_sdo_off; cs_n[*4] |=> !sdo_oe; endproperty
  property p_sdo_on; !cs_n[*4] |=> sdo_oe; endproperty
  property p_od; gpio_o == 2'h0; endproperty
  property p_cal; s_rp |=> gain_cal == 16'h8000 && zero_cal == 16'h0000; endproperty
  property p_rdac;
    s_rp ##0 $stable(group_bipolar) |=>
      dac_level[0] == (group_bipolar[0] ? 16'h8000 : 16'h0000);
  endproperty
  property p_pol_a; group_a_polarity_sel[*4] |=> !group_bipolar[0]; endproperty
  property p_pol_b; !group_b_polarity_sel[*4] |=> group_bipolar[1]; endproperty
  property p_hold; s_hold |=> $stable(dac_level[0]) && $stable(dac_level[3]); endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("sdo driven");
  a_sdo_on: assert property (p_sdo_on) else $error("sdo not driven");
  a_od: assert property (p_od) else $error("gpio driven high");
  a_cal: assert property (p_cal) else $error("cal not reset");
  a_rdac: assert property (p_rdac) else $error("level not reset");
  a_pol_a: assert property (p_pol_a) else $error("group a mode");
  a_pol_b: assert property (p_pol_b) else $error("group b mode");
  a_hold: assert property (p_hold) else $error("latch moved");
endmodule : quad_dac_pin_control_sva

bind quad_dac_pin_control quad_dac_pin_control_sva chk_u (.clk, .rst, .ce, .cs_n, .sdo_oe,
  .latch_load_n, .reset_pin_n, .group_a_polarity_sel, .group_b_polarity_sel, .gpio_o,
  .group_bipolar, .gain_cal, .zero_cal, .dac_level);

// File: sim/tb_quad_dac_pin_control.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_quad_dac_pin_control;
  import quad_dac_pkg::*;
  logic       clk = 1'h0, rst = 1'h0, ce = 1'h1, sclk, cs_n, sdi, sdo, sdo_oe;
  logic       latch_load_n = 1'h1, reset_pin_n = 1'h1;
  logic       group_a_polarity_sel = 1'h1, group_b_polarity_sel = 1'h1;
  logic [1:0] ext = 2'h3, gpio_i, gpio_o, gpio_oe, gpio_state, group_bipolar;
  code_t      gain_cal, zero_cal, dac_level [4];
  int         errors = 0, checks = 0, inr[4], lat[4];
  // pull-up wire: low when the device or the outside pulls
  assign gpio_i = ~gpio_oe & ext;
  always #50 clk = ~clk;
  spi_host host_u (.sclk, .cs_n, .sdi, .sdo);
  quad_dac_pin_control dut_u (.clk, .rst, .ce, .sclk, .cs_n, .sdi, .sdo, .sdo_oe,
    .latch_load_n, .reset_pin_n, .group_a_polarity_sel, .group_b_polarity_sel, .gpio_i,
    .gpio_o, .gpio_oe, .gpio_state, .dac_level, .group_bipolar, .gain_cal, .zero_cal);
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [23:0] w);
    host_u.xfer(w, 24);
    repeat (6) @(negedge clk);
  endtask : wr
  task automatic chk_dac();
    for (int c = 0; c < 4; c++)
      `CHK("dac", 16'(lat[c]) ^ (((c < 2) ? group_a_polarity_sel : group_b_polarity_sel) ?
        16'h0000 : 16'h8000), dac_level[c])
  endtask : chk_dac
  initial begin
    // a real rising edge, so the link-side toggle clears too
    #1 rst = 1'h1;
    void'($urandom(32'hdf54));
    repeat (3) @(negedge clk);
    rst = 1'h0;
    `CHK("gain", 16'h8000, gain_cal)
    for (int r = 0; r < 5; r++) begin
      {group_a_polarity_sel, group_b_polarity_sel} = 2'($urandom);
      for (int c = 0; c < 4; c++) begin
        inr[c] = 16'($urandom);
        wr({4'($urandom), 4'(4 + c), 16'(inr[c])});
      end
      chk_dac();
      latch_load_n = 1'h0;
      repeat (5) @(negedge clk);
      lat = inr;
      chk_dac();
      latch_load_n = 1'h1;
    end
    // aborted partial frame must not shift later frames
    host_u.xfer({8'h01, 16'h5a5a}, 12);
    wr({8'h02, 16'h1234});
    wr({8'h03, 16'hffff});
    `CHK("zero", 16'h1234, zero_cal)
    `CHK("gain", 16'h8000, gain_cal)
    `CHK("sdo", 24'h021234, host_u.rx)
    `CHK("sdo_oe", 1'h0, sdo_oe)
    ce = 1'h0;
    wr({8'h02, 16'h2468});
    `CHK("zero", 16'h1234, zero_cal)
    ce = 1'h1;
    repeat (4) @(negedge clk);
    `CHK("zero", 16'h2468, zero_cal)
    for (int d = 0; d < 4; d++) begin
      ext = 2'($urandom);
      wr({8'h00, 14'h0, 2'(d)});
      repeat (4) @(negedge clk);
      `CHK("oe", 2'(d), gpio_oe)
      `CHK("pin", ~2'(d) & ext, gpio_state)
    end
    wr({8'h01, 16'h0f0f});
    `CHK("gain", 16'h0f0f, gain_cal)
    reset_pin_n = 1'h0;
    repeat (5) @(negedge clk);
    lat = '{0, 0, 0, 0};
    chk_dac();
    `CHK("gain", 16'h8000, gain_cal)
    `CHK("zero", 16'h0000, zero_cal)
    reset_pin_n = 1'h1;
    stop_test();
  end
  initial begin
    #2000000;
    errors++;
    stop_test();
  end
endmodule : tb_quad_dac_pin_control
